/* isr_pkg.sv */
// Shared constants and types for the two-wire slave receive block.
package isr_pkg;

    localparam logic [3:0] ISR_LAST_DATA_BIT = 4'h8;
    localparam logic [3:0] ISR_ACK_BIT       = 4'h9;
    localparam logic [3:0] ISR_CNT_RST       = 4'h0;
    localparam logic [4:0] ISR_TEN_HEADER    = 5'h1E;
    localparam logic [7:0] ISR_ADDR_RST      = 8'h00;
    localparam logic [7:0] ISR_BUF_RST       = 8'h00;
    localparam logic [7:0] ISR_SHIFT_RST     = 8'h00;
    localparam int         ISR_HDR_MSB       = 7;
    localparam int         ISR_HDR_LSB       = 3;
    localparam int         ISR_A98_MSB       = 2;
    localparam int         ISR_A98_LSB       = 1;
    localparam int         ISR_RW_BIT        = 0;

    typedef enum logic [2:0] {
        ISR_IDLE,
        ISR_ADDR1,
        ISR_ADDR2,
        ISR_DATA,
        ISR_SKIP
    } isr_state_e;

endpackage : isr_pkg

/* isr_link.sv */
// Link-side shift register clocked by the serial clock line.
`timescale 1ns/1ps
module isr_link
    import isr_pkg::*;
(
    input  wire logic       scl_clk,
    input  wire logic       sda_in,
    output logic [7:0]      shift_q
);

    typedef struct packed {
        logic [7:0] sr;
    } isr_link_s;

    isr_link_s r;
    isr_link_s n;

    // No reset: the serial clock may be still during reset, and eight
    // edges after every Start refill the register anyway.
    always_comb begin
        n    = r;
        n.sr = {r.sr[6:0], sda_in};
    end

    always_ff @(posedge scl_clk) begin
        r <= n;
    end

    assign shift_q = r.sr;

endmodule : isr_link

/* isr_slave_rx.sv */
// Two-wire slave receiver: Start, address match, acknowledge and flags.
`timescale 1ns/1ps
// Functional notes
// - Idle until Start, then shift eight bits.
// - Sample data on rising serial clock.
// - Compare shift bits 7..1 with address.
// - Compare on eighth clock falling edge.
// - Match and room: load, set full, acknowledge.
// - Interrupt flag set on ninth falling edge.
// - Ten-bit header 11110 carries A9, A8.
// - High address byte sets flag, full, update.
// - Address write clears update, frees clock.
// - Buffer read clears full; software clears flag.
// - Low byte sets update; reload releases clock.
// - Repeated Start header sets flag, full and direction, not update.
// - Data byte loaded only when room exists.
// - Matched write address clears direction bit.
// - No acknowledge while full or overflow.
// - Flag set every matched byte, sticky until cleared.
module isr_slave_rx
    import isr_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RSTN,
    input  wire logic       SCL_IN,
    output logic            SCL_OUT,
    output logic            SCL_OE_N,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N,
    input  wire logic       ENABLE,
    input  wire logic       TEN_BIT_MODE,
    input  wire logic       ADDR_WR,
    input  wire logic [7:0] ADDR_WDATA,
    input  wire logic       BUF_RD,
    input  wire logic       IF_CLR,
    input  wire logic       OV_CLR,
    output logic [7:0]      SLAVE_ADDR,
    output logic [7:0]      RX_BUF,
    output logic            BUF_FULL,
    output logic            OVERFLOW,
    output logic            PORT_IRQ_FLAG,
    output logic            UPDATE_ADDR,
    output logic            RW_STATUS
);

    typedef struct packed {
        isr_state_e st;
        logic       scl_m;
        logic       scl_s;
        logic       scl_d;
        logic       sda_m;
        logic       sda_s;
        logic       sda_d;
        logic [3:0] cnt;
        logic [7:0] addr;
        logic [7:0] rxbuf;
        logic       bf;
        logic       ov;
        logic       iflag;
        logic       ua;
        logic       rw;
        logic       ack;
        logic       pend;
        logic       ten_done;
        logic       scl_oe_n;
        logic       sda_oe_n;
    } isr_regs_s;

    isr_regs_s  r;
    isr_regs_s  n;
    logic [7:0] sr_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       eval8;
    logic       end9;
    logic       room;
    logic       hdr_ok;

    // The shift register lives on the serial clock; it is read here only
    // after the eighth rising edge, while it stays still until the ninth.
    isr_link u_link (
        .scl_clk (SCL_IN),
        .sda_in  (SDA_IN),
        .shift_q (sr_q)
    );

    // Edges are taken from the second synchroniser stage and its delay.
    // The serial clock must stay several system clocks in each phase.
    assign scl_rise  = r.scl_s & ~r.scl_d;
    assign scl_fall  = ~r.scl_s & r.scl_d;
    assign start_det = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
    assign stop_det  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
    assign eval8     = scl_fall & (r.cnt == ISR_LAST_DATA_BIT);
    assign end9      = scl_fall & (r.cnt == ISR_ACK_BIT);
    assign room      = ~r.bf & ~r.ov;
    assign hdr_ok    = (sr_q[ISR_HDR_MSB:ISR_HDR_LSB] == ISR_TEN_HEADER) &&
                       (sr_q[ISR_A98_MSB:ISR_A98_LSB] ==
                        r.addr[ISR_A98_MSB:ISR_A98_LSB]);

    always_comb begin
        logic matched;
        logic set_ua;
        logic set_bf;
        logic set_if;
        logic set_ov;
        matched = 1'b0;
        set_ua  = 1'b0;
        set_bf  = 1'b0;
        set_if  = 1'b0;
        set_ov  = 1'b0;
        n       = r;
        n.scl_m = SCL_IN;
        n.scl_s = r.scl_m;
        n.scl_d = r.scl_s;
        n.sda_m = SDA_IN;
        n.sda_s = r.sda_m;
        n.sda_d = r.sda_s;

        if (scl_rise && r.cnt != ISR_ACK_BIT) begin
            n.cnt = 4'(r.cnt + 4'h1);
        end

        if (eval8) begin
            case (r.st)
                ISR_ADDR1: begin
                    if (TEN_BIT_MODE) begin
                        if (hdr_ok && r.ten_done) begin
                            matched = 1'b1;
                            n.st    = sr_q[ISR_RW_BIT] ? ISR_SKIP : ISR_DATA;
                        end else if (hdr_ok && !sr_q[ISR_RW_BIT]) begin
                            matched = 1'b1;
                            set_ua  = 1'b1;
                            n.st    = ISR_ADDR2;
                        end else begin
                            n.st = ISR_SKIP;
                        end
                    end else if (sr_q[7:1] == r.addr[7:1]) begin
                        matched = 1'b1;
                        n.st    = sr_q[ISR_RW_BIT] ? ISR_SKIP : ISR_DATA;
                    end else begin
                        n.st = ISR_SKIP;
                    end
                end
                ISR_ADDR2: begin
                    if (sr_q == r.addr) begin
                        matched    = 1'b1;
                        set_ua     = 1'b1;
                        n.ten_done = 1'b1;
                        n.st       = ISR_DATA;
                    end else begin
                        n.st = ISR_SKIP;
                    end
                end
                ISR_DATA: begin
                    matched = 1'b1;
                    if (r.bf) begin
                        set_ov = 1'b1;
                    end
                end
                default: begin
                    matched = 1'b0;
                end
            endcase
            if (matched) begin
                set_bf = 1'b1;
                n.pend = 1'b1;
                // The low address byte has no direction bit of its own.
                if (r.st == ISR_ADDR1) begin
                    n.rw = sr_q[ISR_RW_BIT];
                end
                if (room) begin
                    n.rxbuf = sr_q;
                    n.ack   = 1'b1;
                end
            end
        end

        if (end9) begin
            n.ack  = 1'b0;
            n.cnt  = ISR_CNT_RST;
            n.pend = 1'b0;
            set_if = r.pend;
        end

        // Software writes and reads; a hardware set in the same cycle wins.
        if (ADDR_WR) begin
            n.addr = ADDR_WDATA;
            n.ua   = 1'b0;
        end
        if (BUF_RD) begin
            n.bf = 1'b0;
        end
        if (IF_CLR) begin
            n.iflag = 1'b0;
        end
        if (OV_CLR) begin
            n.ov = 1'b0;
        end
        if (set_ua) begin
            n.ua = 1'b1;
        end
        if (set_bf && room) begin
            n.bf = 1'b1;
        end
        if (set_if) begin
            n.iflag = 1'b1;
        end
        if (set_ov) begin
            n.ov = 1'b1;
        end

        if (stop_det) begin
            n.st       = ISR_IDLE;
            n.ten_done = 1'b0;
            n.ack      = 1'b0;
            n.pend     = 1'b0;
        end
        if (start_det) begin
            n.st   = ISR_ADDR1;
            n.cnt  = ISR_CNT_RST;
            n.ack  = 1'b0;
            n.pend = 1'b0;
        end
        if (!ENABLE) begin
            n.st       = ISR_IDLE;
            n.ten_done = 1'b0;
            n.ack      = 1'b0;
            n.pend     = 1'b0;
        end

        n.scl_oe_n = ~n.ua;
        n.sda_oe_n = ~n.ack;
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            r.st       <= ISR_IDLE;
            r.scl_m    <= 1'b1;
            r.scl_s    <= 1'b1;
            r.scl_d    <= 1'b1;
            r.sda_m    <= 1'b1;
            r.sda_s    <= 1'b1;
            r.sda_d    <= 1'b1;
            r.cnt      <= ISR_CNT_RST;
            r.addr     <= ISR_ADDR_RST;
            r.rxbuf    <= ISR_BUF_RST;
            r.bf       <= 1'b0;
            r.ov       <= 1'b0;
            r.iflag    <= 1'b0;
            r.ua       <= 1'b0;
            r.rw       <= 1'b0;
            r.ack      <= 1'b0;
            r.pend     <= 1'b0;
            r.ten_done <= 1'b0;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // The pins are only ever pulled low, so the driven level is fixed.
    assign SCL_OUT       = 1'b0;
    assign SDA_OUT       = 1'b0;
    assign SCL_OE_N      = r.scl_oe_n;
    assign SDA_OE_N      = r.sda_oe_n;
    assign SLAVE_ADDR    = r.addr;
    assign RX_BUF        = r.rxbuf;
    assign BUF_FULL      = r.bf;
    assign OVERFLOW      = r.ov;
    assign PORT_IRQ_FLAG = r.iflag;
    assign UPDATE_ADDR   = r.ua;
    assign RW_STATUS     = r.rw;

    // Every check here lives on the system clock and sleeps through reset.
    default clocking isr_sys_cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    chk_ack_needs_room: assert property (
        $fell(SDA_OE_N) |-> !$past(r.bf) && !$past(r.ov))
        else $error("Acknowledge given while full or overflowed.");

    chk_ack_sets_full: assert property (
        $fell(SDA_OE_N) |-> BUF_FULL && RX_BUF == $past(sr_q))
        else $error("Acknowledge without buffer load.");

    chk_ack_on_eighth: assert property (
        $fell(SDA_OE_N) |->
            $past(r.cnt) == ISR_LAST_DATA_BIT && $past(scl_fall))
        else $error("Acknowledge not on eighth falling edge.");

    chk_flag_on_ninth: assert property (
        $rose(PORT_IRQ_FLAG) |->
            $past(r.cnt) == ISR_ACK_BIT && $past(scl_fall))
        else $error("Interrupt flag set off the ninth falling edge.");

    chk_flag_sticky: assert property (
        PORT_IRQ_FLAG && !IF_CLR |=> PORT_IRQ_FLAG)
        else $error("Interrupt flag dropped without software clear.");

    chk_addr_wr_release: assert property (
        ADDR_WR && UPDATE_ADDR && !eval8 |=> !UPDATE_ADDR && SCL_OE_N)
        else $error("Address write did not release the clock.");

    chk_buf_rd_clears: assert property (
        BUF_RD && !eval8 |=> !BUF_FULL)
        else $error("Buffer read did not clear full flag.");

    chk_start_resets: assert property (
        start_det && ENABLE |=> r.st == ISR_ADDR1 && r.cnt == ISR_CNT_RST)
        else $error("Start did not begin address phase.");

    chk_stop_idles: assert property (
        stop_det && !start_det |=> r.st == ISR_IDLE ##0 SDA_OE_N)
        else $error("Stop did not return to idle.");

endmodule : isr_slave_rx

/* isr_bus_master.sv */
// Behavioural two-wire bus master that drives the receiver under test.
`timescale 1ns/1ps
module isr_bus_master (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_pull_n,
    output logic      sda_pull_n
);
    localparam int HALF = 100;

    initial begin
        scl_pull_n = 1'b1;
        sda_pull_n = 1'b1;
    end

    // The slave may stretch the low phase, so the wait for high is bounded.
    task automatic clk_high;
        int n;
        n = 0;
        scl_pull_n = 1'b1;
        while (scl_line !== 1'b1 && n < 400) begin
            #10;
            n++;
        end
        #HALF;
    endtask : clk_high

    // SDA moves only well after SCL falls, so no false Start or Stop is seen.
    task automatic clk_low;
        scl_pull_n = 1'b0;
        #20;
    endtask : clk_low

    task automatic start;
        #3;
        sda_pull_n = 1'b1;
        #HALF;
        clk_high();
        sda_pull_n = 1'b0;
        #HALF;
        clk_low();
    endtask : start

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull_n = b[i];
            #HALF;
            clk_high();
            clk_low();
        end
        sda_pull_n = 1'b1;
        #HALF;
        clk_high();
        ack = ~sda_line;
        clk_low();
        #HALF;
    endtask : send_byte

    task automatic stop;
        sda_pull_n = 1'b0;
        #HALF;
        clk_high();
        sda_pull_n = 1'b1;
        #HALF;
    endtask : stop
endmodule : isr_bus_master

/* test_isr_slave_rx.sv */
// Self-checking bench for the two-wire slave receiver.
`timescale 1ns/1ps
module test_isr_slave_rx;
    logic       mclk, rstn, en, ten, addr_wr, buf_rd, if_clr, ov_clr;
    logic [7:0] addr_wdata, slave_addr, rx_buf;
    logic       scl_out, scl_oe_n, sda_out, sda_oe_n, buf_full, overflow;
    logic       irq, upd, rw, m_scl_n, m_sda_n, ack;
    wire        scl = (scl_oe_n ? 1'b1 : scl_out) & m_scl_n;
    wire        sda = (sda_oe_n ? 1'b1 : sda_out) & m_sda_n;
    int         bad_count, checks;

    isr_slave_rx u_isr_slave_rx (
        .MCLK(mclk), .RSTN(rstn), .SCL_IN(scl), .SCL_OUT(scl_out),
        .SCL_OE_N(scl_oe_n), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .ENABLE(en), .TEN_BIT_MODE(ten),
        .ADDR_WR(addr_wr), .ADDR_WDATA(addr_wdata), .BUF_RD(buf_rd),
        .IF_CLR(if_clr), .OV_CLR(ov_clr), .SLAVE_ADDR(slave_addr),
        .RX_BUF(rx_buf), .BUF_FULL(buf_full), .OVERFLOW(overflow),
        .PORT_IRQ_FLAG(irq), .UPDATE_ADDR(upd), .RW_STATUS(rw)
    );

    isr_bus_master u_isr_bus_master (
        .scl_line(scl), .sda_line(sda),
        .scl_pull_n(m_scl_n), .sda_pull_n(m_sda_n)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic test_done;
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Op bits are address write, buffer read, flag clear, overflow clear.
    task automatic sw(input logic [3:0] op, input logic [7:0] d);
        @(posedge mclk);
        {addr_wr, buf_rd, if_clr, ov_clr} <= op;
        addr_wdata <= d;
        @(posedge mclk);
        {addr_wr, buf_rd, if_clr, ov_clr} <= 4'h0;
        @(posedge mclk);
        #1;
    endtask : sw

    // The flag rises a few system clocks after the ninth fall, so wait.
    task automatic xfer(input logic [7:0] b, input logic exp_ack);
        u_isr_bus_master.send_byte(b, ack);
        repeat (10) @(posedge mclk);
        #1;
        chk({7'h00, ack}, {7'h00, exp_ack});
    endtask : xfer

    // Flags are full, overflow, interrupt, update and direction.
    task automatic st(input logic [4:0] f, input logic [7:0] b);
        chk({3'h0, buf_full, overflow, irq, upd, rw}, {3'h0, f});
        chk(rx_buf, b);
    endtask : st

    // An address byte that sets the update flag stalls the ninth clock
    // until software reloads the address, so software runs beside it.
    task automatic xfer_ua(input logic [7:0] b, input logic [7:0] nxt);
        fork
            xfer(b, 1'b1);
            begin
                wait (upd === 1'b1);
                repeat (2) @(posedge mclk);
                #1;
                st(5'h12, b);
                chk({7'h00, scl_oe_n}, 8'h00);
                sw(4'h8, nxt);
                chk({7'h00, scl_oe_n}, 8'h01);
            end
        join
    endtask : xfer_ua

    // Whole run needs about 23 us; a hang is cut off well beyond that.
    initial begin
        #300000;
        bad_count++;
        test_done();
    end

    initial begin
        {rstn, en, ten, addr_wr, buf_rd, if_clr, ov_clr} = 7'h00;
        addr_wdata = 8'h00;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        en <= 1'b1;
        @(posedge mclk);
        #1;
        st(5'h00, 8'h00);
        chk({5'h00, scl_oe_n, sda_oe_n, slave_addr[0]}, 8'h06);
        sw(4'h8, 8'hA4);
        chk(slave_addr, 8'hA4);
        repeat (4) @(posedge mclk);
        u_isr_bus_master.start();
        xfer(8'hA4, 1'b1);
        st(5'h14, 8'hA4);
        sw(4'h2, 8'hA4);
        xfer(8'h5A, 1'b0);
        st(5'h1C, 8'hA4);
        sw(4'h6, 8'hA4);
        xfer(8'h3C, 1'b0);
        st(5'h0C, 8'hA4);
        sw(4'h7, 8'hA4);
        xfer(8'h3C, 1'b1);
        st(5'h14, 8'h3C);
        u_isr_bus_master.stop();
        sw(4'h6, 8'hA4);
        u_isr_bus_master.start();
        xfer(8'h22, 1'b0);
        xfer(8'h11, 1'b0);
        st(5'h00, 8'h3C);
        u_isr_bus_master.stop();
        @(posedge mclk) ten <= 1'b1;
        sw(4'h8, 8'hF4);
        u_isr_bus_master.start();
        xfer_ua(8'hF4, 8'hB5);
        chk(slave_addr, 8'hB5);
        st(5'h14, 8'hF4);
        sw(4'h6, 8'h00);
        st(5'h00, 8'hF4);
        xfer_ua(8'hB5, 8'hF4);
        chk(slave_addr, 8'hF4);
        st(5'h14, 8'hB5);
        sw(4'h6, 8'h00);
        st(5'h00, 8'hB5);
        u_isr_bus_master.start();
        xfer(8'hF5, 1'b1);
        st(5'h15, 8'hF5);
        u_isr_bus_master.stop();
        test_done();
    end
endmodule : test_isr_slave_rx
